// ==== hdl/ubb_port.sv ====
// one channel of the parallel bit-bang port: pins, strobes, host queues, axi4-lite registers
// assumes queue handshakes and the bus run on i_ref_clk; pin inputs are asynchronous
// How it works
// - each channel instance is set to off, asynchronous or synchronous bit-bang on its own
// - asynchronous mode drives the internal read and write strobes onto their output pins
// - asynchronous mode drives host bytes onto output pins paced by the baud generator
// - asynchronous outputs change only on new byte plus baud tick, else hold
// - an eight-bit direction mask comes with mode select and holds until the next
// - mode value 1 selects asynchronous, value 4 selects synchronous bit-bang
// - synchronous outputs change only when a host byte arrives, then write strobe pulses
// - synchronous pins are sampled only when a byte is written, never unsolicited
// - synchronous mode processes a byte only while the to-host queue has room
// - pins are sampled before the new byte is applied, one byte behind
// - sample with strobe low, strobe high while forwarding, low again as outputs change
// - one cycle of data setup after outputs change, then write strobe pulses
// - write strobe follows the taking of a byte from the from-host queue
// - read strobe rising edge outside a write pulse marks the sample placed into the to-host queue
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
module ubb_port #(
   parameter int WIDTH = 8,
   parameter int BAUD_W = 16
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // axi4-lite slave
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // from-host queue
   input wire logic [7:0] i_from_host_queue_data,
   input wire logic i_from_host_queue_valid,
   output logic o_from_host_queue_ready,
   // to-host queue
   output logic [7:0] o_to_host_queue_data,
   output logic o_to_host_queue_valid,
   input wire logic i_to_host_queue_ready,
   // parallel pins
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_pin,
   output logic [WIDTH-1:0] o_pin_oe,
   output logic o_pin_sample_strobe_n,
   output logic o_pin_update_strobe_n
);
   if (WIDTH != 8) $error("ubb_port serves an 8-bit pin group only");
   if (BAUD_W < 1 || BAUD_W > 16) $error("ubb_port baud width must be 1..16");

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_READ = 5'h02,
      ST_FWD = 5'h04,
      ST_SETUP = 5'h08,
      ST_WRITE = 5'h10
   } ubb_state_t;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // ***********************************************************
   // pin synchroniser
   // ***********************************************************
   logic [WIDTH-1:0] pin_meta;
   logic [WIDTH-1:0] pin_sync;
   always_ff @(posedge i_ref_clk) begin
      pin_meta <= i_pin;
      pin_sync <= pin_meta;
   end

   // ***********************************************************
   // register bus
   // ***********************************************************
   logic [7:0] mode, next_mode;
   logic [7:0] dir, next_dir;
   logic [BAUD_W-1:0] baud, next_baud;
   logic aw_held, next_aw_held;
   logic w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   logic mode_written;
   ubb_state_t state, next_state;
   logic [WIDTH-1:0] pin_out;
   logic th_valid;

   assign o_awready = !aw_held && !bvalid;
   assign o_wready = !w_held && !bvalid;
   assign o_arready = !rvalid;
   assign o_bvalid = bvalid;
   assign o_bresp = bresp;
   assign o_rvalid = rvalid;
   assign o_rdata = rdata;
   assign o_rresp = rresp;

   always_comb begin
      logic [31:0] ctrl_word;
      logic [31:0] merged;
      ctrl_word = '0;
      merged = '0;
      next_mode = mode;
      next_dir = dir;
      next_baud = baud;
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      mode_written = 1'b0;
      // write address and data are taken in either order
      if (i_awvalid && o_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         next_w_held = 1'b1;
         next_w_data = i_wdata;
         next_w_strb = i_wstrb;
      end
      if (aw_held && w_held) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = ubb_pkg::RESP_OKAY;
         ctrl_word[ubb_pkg::CTRL_MODE_LSB +: 8] = mode;
         ctrl_word[ubb_pkg::CTRL_DIR_LSB +: 8] = dir;
         unique case (aw_addr)
            ubb_pkg::ADDR_CTRL: begin
               // mode and direction are one command; each field moves only where its byte strobe is set
               merged = merge(ctrl_word, w_data, w_strb);
               next_mode = merged[ubb_pkg::CTRL_MODE_LSB +: 8];
               next_dir = merged[ubb_pkg::CTRL_DIR_LSB +: 8];
               mode_written = 1'b1;
            end
            ubb_pkg::ADDR_BAUD: begin
               merged = merge({{(32-BAUD_W){1'b0}}, baud}, w_data, w_strb);
               next_baud = merged[BAUD_W-1:0];
            end
            ubb_pkg::ADDR_STATUS: next_bresp = ubb_pkg::RESP_OKAY;
            default: next_bresp = ubb_pkg::RESP_SLVERR;
         endcase
      end
      if (bvalid && i_bready) next_bvalid = 1'b0;
      if (rvalid && i_rready) next_rvalid = 1'b0;
      if (i_arvalid && o_arready) begin
         next_rvalid = 1'b1;
         next_rresp = ubb_pkg::RESP_OKAY;
         next_rdata = '0;
         unique case (i_araddr)
            ubb_pkg::ADDR_CTRL: begin
               next_rdata[ubb_pkg::CTRL_MODE_LSB +: 8] = mode;
               next_rdata[ubb_pkg::CTRL_DIR_LSB +: 8] = dir;
            end
            ubb_pkg::ADDR_BAUD: next_rdata[BAUD_W-1:0] = baud;
            ubb_pkg::ADDR_STATUS: begin
               next_rdata[ubb_pkg::STAT_PINS_LSB +: 8] = pin_sync;
               next_rdata[ubb_pkg::STAT_OUT_LSB +: 8] = pin_out;
               next_rdata[ubb_pkg::STAT_BUSY_BIT] = (state != ST_IDLE);
               next_rdata[ubb_pkg::STAT_PEND_BIT] = th_valid;
            end
            default: next_rresp = ubb_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         mode <= ubb_pkg::RST_MODE;
         dir <= ubb_pkg::RST_DIR;
         baud <= ubb_pkg::RST_BAUD[BAUD_W-1:0];
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= ubb_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= ubb_pkg::RESP_OKAY;
      end else begin
         mode <= next_mode;
         dir <= next_dir;
         baud <= next_baud;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // ***********************************************************
   // bit-bang engine
   // ***********************************************************
   logic is_async;
   logic is_sync;
   logic tick;
   logic [BAUD_W-1:0] baud_cnt, next_baud_cnt;
   logic [WIDTH-1:0] next_pin_out;
   logic [WIDTH-1:0] pin_oe, next_pin_oe;
   logic [7:0] th_data, next_th_data;
   logic next_th_valid;
   logic rd_n, next_rd_n;
   logic wr_n, next_wr_n;
   logic take;

   assign is_async = (mode == ubb_pkg::MODE_ASYNC);
   assign is_sync = (mode == ubb_pkg::MODE_SYNC);
   assign tick = (baud_cnt == '0);
   // async takes a byte only on a tick; sync takes it once the sample is queued
   assign take = i_from_host_queue_valid &&
                 ((is_async && tick) || (state == ST_SETUP));
   assign o_from_host_queue_ready = (is_async && tick) || (state == ST_SETUP);
   assign o_to_host_queue_data = th_data;
   assign o_to_host_queue_valid = th_valid;
   assign o_pin = pin_out;
   assign o_pin_oe = pin_oe;
   assign o_pin_sample_strobe_n = rd_n;
   assign o_pin_update_strobe_n = wr_n;

   always_comb begin
      next_state = state;
      next_baud_cnt = tick ? baud : baud_cnt - 1'b1;
      next_pin_out = pin_out;
      next_pin_oe = (is_async || is_sync) ? dir : '0;
      next_th_data = th_data;
      next_th_valid = th_valid;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      if (th_valid && i_to_host_queue_ready) next_th_valid = 1'b0;
      if (is_async) begin
         if (take) begin
            next_pin_out = i_from_host_queue_data;
            next_wr_n = 1'b0;
         end
         // sample on the same pace; a sample still waiting is not overwritten
         if (tick && !next_th_valid) begin
            next_th_data = pin_sync;
            next_th_valid = 1'b1;
            next_rd_n = 1'b0;
         end
      end
      unique case (state)
         ST_IDLE: begin
            // room for the sample must exist before the byte is touched
            if (is_sync && i_from_host_queue_valid && i_to_host_queue_ready && !th_valid)
               next_state = ST_READ;
         end
         ST_READ: begin
            next_th_data = pin_sync;
            next_rd_n = 1'b0;
            next_state = ST_FWD;
         end
         ST_FWD: begin
            // strobe goes back high as the sample enters the queue
            next_th_valid = 1'b1;
            next_state = ST_SETUP;
         end
         ST_SETUP: begin
            if (take) begin
               next_pin_out = i_from_host_queue_data;
               next_rd_n = 1'b0;
               next_state = ST_WRITE;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_WRITE: begin
            // the new pins have had one cycle of setup when the strobe falls
            next_wr_n = 1'b0;
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // a new mode select abandons any cycle in flight
      if (mode_written) next_state = ST_IDLE;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= ST_IDLE;
         baud_cnt <= ubb_pkg::RST_BAUD[BAUD_W-1:0];
         pin_out <= ubb_pkg::RST_PIN_OUT;
         pin_oe <= ubb_pkg::RST_DIR;
         th_data <= 8'h00;
         th_valid <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end else begin
         state <= next_state;
         baud_cnt <= next_baud_cnt;
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         th_data <= next_th_data;
         th_valid <= next_th_valid;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
      end
   end
endmodule

// ==== hdl/ubb_pkg.sv ====
// constants for the parallel bit-bang port: register map, field layout, mode codes
// assumes a 32-bit axi4-lite register bus and an 8-bit parallel pin group
package ubb_pkg;
   // ***********************************************************
   // register map (byte addresses)
   // ***********************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DIR_LSB = 8;
   localparam int STAT_PINS_LSB = 0;
   localparam int STAT_OUT_LSB = 8;
   localparam int STAT_BUSY_BIT = 16;
   localparam int STAT_PEND_BIT = 17;
   // ***********************************************************
   // mode codes carried by the mode select command
   // ***********************************************************
   localparam logic [7:0] MODE_OFF = 8'h00;
   localparam logic [7:0] MODE_ASYNC = 8'h01;
   localparam logic [7:0] MODE_SYNC = 8'h04;
   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_PIN_OUT = 8'h00;
   localparam logic [15:0] RST_BAUD = 16'h0010;
   // ***********************************************************
   // bus responses
   // ***********************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verification/ubb_port_sva.sv ====
// concurrent checks on the ports of one bit-bang channel
// assumes the single i_ref_clk domain and the synchronous active-high i_rst
module ubb_port_sva (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // register bus
   input wire logic o_awready,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic i_rready,
   // host queues
   input wire logic i_from_host_queue_valid,
   input wire logic o_from_host_queue_ready,
   input wire logic [7:0] o_to_host_queue_data,
   input wire logic o_to_host_queue_valid,
   input wire logic i_to_host_queue_ready,
   // pins
   input wire logic [7:0] o_pin,
   input wire logic [7:0] o_pin_oe,
   input wire logic o_pin_sample_strobe_n,
   input wire logic o_pin_update_strobe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   assign take = i_from_host_queue_valid && o_from_host_queue_ready;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // ***********************************************************
   // assertions
   // ***********************************************************
   AST_RESET_IDLE: assert property ($fell(i_rst) |-> o_pin_sample_strobe_n &&
      o_pin_update_strobe_n && !o_to_host_queue_valid && o_pin_oe == 8'h00)
      else $error("strobes or outputs not idle after reset");
   AST_UPD_PULSE: assert property ($fell(o_pin_update_strobe_n) |=> o_pin_update_strobe_n)
      else $error("update strobe longer than one cycle");
   // a pin change needs a byte taken one or two edges before it
   AST_PIN_CAUSE: assert property ($changed(o_pin) |-> $past(take) || $past(take, 2))
      else $error("pins changed without a byte from the host");
   AST_UPD_AFTER_PIN: assert property ($changed(o_pin) |-> ##[0:1] !o_pin_update_strobe_n)
      else $error("no update strobe after pin change");
   // a rise outside a write pulse marks a sample that is, or just was, offered
   AST_SAMPLE_VALID: assert property ($rose(o_pin_sample_strobe_n) &&
      o_pin_update_strobe_n |-> o_to_host_queue_valid || $past(o_to_host_queue_valid))
      else $error("sample strobe without a queued sample");
   AST_TH_HOLD: assert property (o_to_host_queue_valid && !i_to_host_queue_ready |=>
      o_to_host_queue_valid && $stable(o_to_host_queue_data)) else $error("sample dropped");
   AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   AST_BUS_REFUSE: assert property ((o_bvalid |-> !o_awready && !o_wready) and
      (o_rvalid |-> !o_arready)) else $error("request taken while answer pending");
   COV_UPD: cover property ($fell(o_pin_update_strobe_n));
   COV_SAMPLE: cover property (o_to_host_queue_valid && i_to_host_queue_ready);
   COV_WRITE: cover property (o_bvalid && i_bready);
endmodule
bind ubb_port ubb_port_sva u_ubb_port_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .o_awready(o_awready), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
   .i_bready(i_bready), .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
   .i_rready(i_rready), .i_from_host_queue_valid(i_from_host_queue_valid),
   .o_from_host_queue_ready(o_from_host_queue_ready), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
   .o_to_host_queue_data(o_to_host_queue_data), .o_to_host_queue_valid(o_to_host_queue_valid),
   .i_to_host_queue_ready(i_to_host_queue_ready), .o_pin_sample_strobe_n(o_pin_sample_strobe_n),
   .o_pin_update_strobe_n(o_pin_update_strobe_n));

// ==== verification/ubb_pin_model.sv ====
// external logic on the parallel pins
// assumes each pin is driven by the port while its enable is high, else by this model
module ubb_pin_model (
   // pin group
   input wire logic [7:0] i_drive,
   input wire logic [7:0] i_oe,
   input wire logic [7:0] i_ext,
   output logic [7:0] o_level
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         o_level[b] = i_oe[b] ? i_drive[b] : i_ext[b];
      end
   end
endmodule

// ==== verification/ubb_port_tb_top.sv ====
// self-checking bench for one bit-bang channel: bus tasks, queue tasks, pin model
// assumes the checker is bound from its own file
module ubb_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rst = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, fh_data = 8'h00, ext = 8'hA0, th_data;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic fh_valid = 1'h0, th_ready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, fh_ready, th_valid, smp_n, upd_n;
   logic [1:0] bresp, rresp, r;
   logic [7:0] pin_in, pin_out, pin_oe;
   logic [7:0] modes [3] = '{ubb_pkg::MODE_ASYNC, ubb_pkg::MODE_SYNC, 8'h02};
   int n_mismatch = 0, n_checks = 0, cyc = 0, t1, t2;
   always #25 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   ubb_port u_ubb_port (.i_ref_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rvalid), .i_rready(rready), .i_from_host_queue_data(fh_data),
      .i_from_host_queue_valid(fh_valid), .o_from_host_queue_ready(fh_ready),
      .o_to_host_queue_data(th_data), .o_to_host_queue_valid(th_valid),
      .i_to_host_queue_ready(th_ready), .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe),
      .o_pin_sample_strobe_n(smp_n), .o_pin_update_strobe_n(upd_n));
   ubb_pin_model u_ubb_pin_model (.i_drive(pin_out), .i_oe(pin_oe), .i_ext(ext), .o_level(pin_in));
   // ***********************************************************
   // tasks
   // ***********************************************************
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic tmo;
      $display("wait limit reached at %0t", $time);
      n_mismatch++;
      finish_test();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // handshakes are judged at the falling edge so the rising edge never races the design
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic ah, wh, bh;
      bh = 1'h0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      for (int k = 0; k < 40 && !bh; k++) begin
         @(negedge clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid && bready;
         r = bresp;
         @(posedge clk);
         if (ah) awvalid <= 1'h0;
         if (wh) wvalid <= 1'h0;
         bready <= !bh && k >= 2;
      end
      if (!bh) tmo();
      chk(r, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      logic ah, hit;
      hit = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      for (int k = 0; k < 40 && !hit; k++) begin
         @(negedge clk);
         ah = arvalid && arready;
         hit = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ah) arvalid <= 1'h0;
         rready <= !hit && k >= 2;
      end
      if (!hit) tmo();
      chk(r, er);
   endtask
   // offer a byte while the to-host side has no room, then release it and take the sample
   task automatic sync_xfer(input logic [7:0] b, input logic [7:0] exp);
      logic tk, gt, hit, q;
      logic [7:0] s;
      tk = 1'h0;
      gt = 1'h0;
      @(posedge clk);
      fh_data <= b;
      fh_valid <= 1'h1;
      th_ready <= 1'h0;
      repeat (20) begin
         @(negedge clk);
         chk(fh_ready, 1'h0);
      end
      @(posedge clk);
      th_ready <= 1'h1;
      for (int k = 0; k < 40 && !(tk && gt); k++) begin
         @(negedge clk);
         hit = fh_valid && fh_ready;
         tk = tk || hit;
         if (th_valid && !gt) {q, s} = {smp_n, th_data};
         gt = gt || th_valid;
         @(posedge clk);
         if (hit) fh_valid <= 1'h0;
      end
      if (!(tk && gt)) tmo();
      chk(s, exp);
      chk(q, 1'h1);
      @(negedge clk);
      chk({smp_n, upd_n, pin_out}, {2'h1, b});
      @(negedge clk);
      chk({smp_n, upd_n}, 2'h2);
      @(posedge clk);
   endtask
   task automatic send(input logic [7:0] b, output int t);
      logic hit;
      hit = 1'h0;
      @(posedge clk);
      fh_data <= b;
      fh_valid <= 1'h1;
      for (int k = 0; k < 40 && !hit; k++) begin
         @(negedge clk);
         hit = fh_valid && fh_ready;
         t = cyc;
         @(posedge clk);
         if (hit) fh_valid <= 1'h0;
      end
      if (!hit) tmo();
      @(negedge clk);
      chk({smp_n, upd_n}, 2'h0);
   endtask
   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rd(ubb_pkg::ADDR_CTRL, ubb_pkg::RESP_OKAY);
      chk(d, 32'h0);
      rd(ubb_pkg::ADDR_BAUD, ubb_pkg::RESP_OKAY);
      chk(d, {16'h0, ubb_pkg::RST_BAUD});
      rd(8'h0C, ubb_pkg::RESP_SLVERR);
      wr(8'h0C, 32'hFFFF_FFFF, ubb_pkg::RESP_SLVERR);
      chk({pin_oe, smp_n, upd_n}, {8'h00, 2'h3});
      $display("test reset done");
      th_ready <= 1'h1;
      foreach (modes[i]) begin
         wr(ubb_pkg::ADDR_CTRL, {16'h0, 8'h5A, modes[i]}, ubb_pkg::RESP_OKAY);
         repeat (2) @(posedge clk);
         chk(pin_oe, (i < 2) ? 8'h5A : 8'h00);
      end
      $display("test modes done");
      wr(ubb_pkg::ADDR_CTRL, {16'h0, 8'hFF, ubb_pkg::MODE_SYNC}, ubb_pkg::RESP_OKAY);
      repeat (30) begin
         @(negedge clk);
         chk(th_valid, 1'h0);
      end
      sync_xfer(8'h55, 8'h00);
      sync_xfer(8'hAA, 8'h55);
      sync_xfer(8'hAA, 8'hAA);
      chk(pin_out, 8'hAA);
      ext <= 8'h3C;
      wr(ubb_pkg::ADDR_CTRL, {16'h0, 8'h00, ubb_pkg::MODE_SYNC}, ubb_pkg::RESP_OKAY);
      sync_xfer(8'h77, 8'h3C);
      $display("test sync done");
      ext <= 8'hA0;
      wr(ubb_pkg::ADDR_BAUD, 32'h3, ubb_pkg::RESP_OKAY);
      wr(ubb_pkg::ADDR_CTRL, {16'h0, 8'h0F, ubb_pkg::MODE_ASYNC}, ubb_pkg::RESP_OKAY);
      send(8'h3C, t1);
      send(8'hC3, t2);
      chk(t2 - t1, 32'h4);
      repeat (20) @(posedge clk);
      chk(pin_out, 8'hC3);
      rd(ubb_pkg::ADDR_STATUS, ubb_pkg::RESP_OKAY);
      chk(d[15:0], 16'hC3A3);
      $display("test async done");
      finish_test();
   end
endmodule
